// ### lmfb_params.svh
`ifndef LMFB_PARAMS_SVH
`define LMFB_PARAMS_SVH
// ==========================================================
// register byte offsets on the apb bus
`define LMFB_OFS_FTB_LO 8'h00
`define LMFB_OFS_FTB_HI 8'h04
`define LMFB_OFS_SDS_LO 8'h08
`define LMFB_OFS_SDS_HI 8'h0C
`define LMFB_OFS_STATUS 8'h10
// ==========================================================
// field widths
`define LMFB_OPEN_W     2
`define LMFB_LVL_W      8
`define LMFB_GLOBAL_W   3
`define LMFB_REMOVAL_W  4
`define LMFB_SHORT_W    3
`define LMFB_COLOURS    3
// ==========================================================
// field positions in fault_threshold_brightness_cfg
`define LMFB_RED_OPEN_LSB    0
`define LMFB_GREEN_OPEN_LSB  2
`define LMFB_BLUE_OPEN_LSB   4
`define LMFB_RSVD_BIT        6
`define LMFB_RB_EN_BIT       7
`define LMFB_RED_LVL_LSB     8
`define LMFB_GREEN_LVL_LSB   16
`define LMFB_BLUE_LVL_LSB    24
`define LMFB_GLOBAL_LSB      32
`define LMFB_REMOVAL_LSB     35
`define LMFB_RED_SHORT_LSB   39
`define LMFB_GREEN_SHORT_LSB 42
`define LMFB_BLUE_SHORT_LSB  45
// ==========================================================
// status register layout
`define LMFB_ST_OPEN_LSB  0
`define LMFB_ST_SHORT_LSB 3
`define LMFB_ST_PEND_FTB  8
`define LMFB_ST_PEND_SDS  9
// ==========================================================
// reset values and writable masks
`define LMFB_COLOUR_RST  8'h7F
`define LMFB_GLOBAL_RST  3'h3
`define LMFB_REMOVAL_RST 4'h7
`define LMFB_FTB_RST {9'h000, `LMFB_REMOVAL_RST, `LMFB_GLOBAL_RST, \
    {3{`LMFB_COLOUR_RST}}, 8'h00}
`define LMFB_FTB_WMASK 48'hFFFF_FFFF_FFBF
`define LMFB_SDS_RST   48'h0800_0540_403C
`define LMFB_SDS_WMASK 48'h1FFF_0FFF_4002
`endif

// ### lmfb_pkg.sv
`default_nettype none
package lmfb_pkg;
    typedef logic [47:0] lmfb_cfg48_t;
    typedef enum logic [1:0] {
        LMFB_IDLE = 2'b00,
        LMFB_ACK  = 2'b01
    } lmfb_apb_state_t;
    typedef struct packed {
        lmfb_apb_state_t fsm;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
        logic [31:0]     stage_ftb;
        logic [31:0]     stage_sds;
        logic            pend_ftb;
        logic            pend_sds;
    } lmfb_top_state_t;
    typedef struct packed {
        lmfb_cfg48_t ftb;
        lmfb_cfg48_t sds;
    } lmfb_store_state_t;
endpackage : lmfb_pkg
`default_nettype wire

// ### lmfb_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lmfb_cfg_if;
    import lmfb_pkg::*;
    logic        wr_ftb;
    logic        wr_sds;
    lmfb_cfg48_t wdata;
    lmfb_cfg48_t ftb;
    lmfb_cfg48_t sds;
    modport ctrl  (output wr_ftb, output wr_sds, output wdata,
                   input ftb, input sds);
    modport store (input wr_ftb, input wr_sds, input wdata,
                   output ftb, output sds);
endinterface : lmfb_cfg_if
`default_nettype wire

// ### lmfb_cfg_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmfb_params.svh"
module lmfb_cfg_store (
    input  wire logic   ref_clk_i,
    input  wire logic   sys_rst_i,
    lmfb_cfg_if.store   cfg
);
    import lmfb_pkg::*;

    lmfb_store_state_t st_reg;
    lmfb_store_state_t st_next;

    // ==========================================================
    // whole-word commit; reserved bits always rebuilt from reset
    always_comb begin
        st_next = st_reg;
        if (cfg.wr_ftb) begin
            st_next.ftb = (cfg.wdata & `LMFB_FTB_WMASK) |
                          (`LMFB_FTB_RST & ~`LMFB_FTB_WMASK);
        end
        if (cfg.wr_sds) begin
            st_next.sds = (cfg.wdata & `LMFB_SDS_WMASK) |
                          (`LMFB_SDS_RST & ~`LMFB_SDS_WMASK);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_reg.ftb <= `LMFB_FTB_RST;
            st_reg.sds <= `LMFB_SDS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg.ftb = st_reg.ftb;
    assign cfg.sds = st_reg.sds;
endmodule : lmfb_cfg_store
`default_nettype wire

// ### lmfb_cfg_top.sv
// How it works
// - red open-load threshold in bits 1-0, reset 00, four supply offsets
// - green open-load threshold in bits 3-2, reset zero, red coding
// - blue open-load threshold in bits 5-4, reset zero, red coding
// - bit 7 enables readback of open and short results, reset off
// - red colour level in bits 15-8, levels 0-255, reset 127
// - green colour level in bits 23-16, levels 0-255, reset 127
// - blue colour level in bits 31-24, levels 0-255, reset 127
// - global level in bits 34-32, levels 0-7, reset 3
// - short removal code n in bits 38-35 means level n+1, reset code 7
// - red short threshold in bits 41-39, reset 000
// - green short threshold in bits 44-42, reset zero
// - blue short threshold in bits 47-45, reset zero, green coding
`timescale 1ns/1ps
`default_nettype none
`include "lmfb_params.svh"
module lmfb_cfg_top (
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [7:0]                 paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    input  wire logic [`LMFB_COLOURS-1:0]   open_load_detect_i,
    input  wire logic [`LMFB_COLOURS-1:0]   short_detect_i,
    output logic      [`LMFB_OPEN_W-1:0]    red_open_thresh_o,
    output logic      [`LMFB_OPEN_W-1:0]    green_open_thresh_o,
    output logic      [`LMFB_OPEN_W-1:0]    blue_open_thresh_o,
    output logic                            fault_readback_en_o,
    output logic      [`LMFB_LVL_W-1:0]     red_colour_level_o,
    output logic      [`LMFB_LVL_W-1:0]     green_colour_level_o,
    output logic      [`LMFB_LVL_W-1:0]     blue_colour_level_o,
    output logic      [`LMFB_GLOBAL_W-1:0]  global_level_o,
    output logic      [`LMFB_REMOVAL_W-1:0] short_removal_level_o,
    output logic      [`LMFB_SHORT_W-1:0]   red_short_thresh_o,
    output logic      [`LMFB_SHORT_W-1:0]   green_short_thresh_o,
    output logic      [`LMFB_SHORT_W-1:0]   blue_short_thresh_o,
    output lmfb_pkg::lmfb_cfg48_t           slew_decouple_scan_cfg_o
);
    import lmfb_pkg::*;

    localparam lmfb_top_state_t TOP_RST = '{
        fsm:       LMFB_IDLE,
        pready:    1'b0,
        pslverr:   1'b0,
        prdata:    32'h0000_0000,
        stage_ftb: 32'(`LMFB_FTB_RST),
        stage_sds: 32'(`LMFB_SDS_RST),
        pend_ftb:  1'b0,
        pend_sds:  1'b0
    };

    lmfb_top_state_t          st_reg;
    lmfb_top_state_t          st_next;
    lmfb_cfg_if               cfg ();
    logic [`LMFB_COLOURS-1:0] open_gated;
    logic [`LMFB_COLOURS-1:0] short_gated;
    logic                     wr_ok;
    logic                     sel_ftb_hi;
    logic                     sel_sds_hi;

    // ==========================================================
    // configuration storage
    lmfb_cfg_store u_store (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .cfg       (cfg)
    );

    // ==========================================================
    // detection results reach software only while readback is on
    genvar gi;
    generate
        for (gi = 0; gi < `LMFB_COLOURS; gi = gi + 1) begin : g_fault
            assign open_gated[gi]  = open_load_detect_i[gi] &
                cfg.ftb[`LMFB_RB_EN_BIT];
            assign short_gated[gi] = short_detect_i[gi] &
                cfg.ftb[`LMFB_RB_EN_BIT];
        end
    endgenerate

    // ==========================================================
    // write commit
    // a low-word write only stages; the high-word write commits all
    // 48 bits at once, so the device never runs on a half-updated word
    assign wr_ok      = (st_reg.fsm == LMFB_ACK) && psel_i && penable_i &&
                        pwrite_i && !st_reg.pslverr;
    assign sel_ftb_hi = (paddr_i == `LMFB_OFS_FTB_HI);
    assign sel_sds_hi = (paddr_i == `LMFB_OFS_SDS_HI);
    assign cfg.wr_ftb = wr_ok && sel_ftb_hi;
    assign cfg.wr_sds = wr_ok && sel_sds_hi;
    assign cfg.wdata  = sel_ftb_hi ?
                        {pwdata_i[15:0], st_reg.stage_ftb} :
                        {pwdata_i[15:0], st_reg.stage_sds};

    // ==========================================================
    // apb slave: one wait state, answer in the second access cycle
    always_comb begin
        logic        hit;
        logic        ro;
        logic [31:0] rd;
        hit = 1'b1;
        ro  = 1'b0;
        rd  = 32'h0000_0000;
        st_next = st_reg;
        case (paddr_i)
            `LMFB_OFS_FTB_LO: rd = cfg.ftb[31:0];
            `LMFB_OFS_FTB_HI: rd = {16'h0000, cfg.ftb[47:32]};
            `LMFB_OFS_SDS_LO: rd = cfg.sds[31:0];
            `LMFB_OFS_SDS_HI: rd = {16'h0000, cfg.sds[47:32]};
            `LMFB_OFS_STATUS: begin
                ro = 1'b1;
                rd[`LMFB_ST_OPEN_LSB +: `LMFB_COLOURS]  = open_gated;
                rd[`LMFB_ST_SHORT_LSB +: `LMFB_COLOURS] = short_gated;
                rd[`LMFB_ST_PEND_FTB] = st_reg.pend_ftb;
                rd[`LMFB_ST_PEND_SDS] = st_reg.pend_sds;
            end
            default: hit = 1'b0;
        endcase
        case (st_reg.fsm)
            LMFB_IDLE: begin
                if (psel_i && penable_i) begin
                    st_next.fsm     = LMFB_ACK;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = !hit || (ro && pwrite_i);
                    st_next.prdata  = (pwrite_i || !hit) ?
                                      32'h0000_0000 : rd;
                end
            end
            LMFB_ACK: begin
                st_next.fsm     = LMFB_IDLE;
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.prdata  = 32'h0000_0000;
                if (wr_ok && paddr_i == `LMFB_OFS_FTB_LO) begin
                    st_next.stage_ftb = pwdata_i;
                    st_next.pend_ftb  = 1'b1;
                end
                if (wr_ok && paddr_i == `LMFB_OFS_SDS_LO) begin
                    st_next.stage_sds = pwdata_i;
                    st_next.pend_sds  = 1'b1;
                end
                if (cfg.wr_ftb) begin
                    st_next.pend_ftb = 1'b0;
                end
                if (cfg.wr_sds) begin
                    st_next.pend_sds = 1'b0;
                end
            end
            default: begin
                st_next = TOP_RST;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_reg <= TOP_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign prdata_o  = st_reg.prdata;
    assign pready_o  = st_reg.pready;
    assign pslverr_o = st_reg.pslverr;

    // open-load codes select supply minus 0.2, 0.5, 0.9 or 1.2 volts
    assign red_open_thresh_o =
        cfg.ftb[`LMFB_RED_OPEN_LSB +: `LMFB_OPEN_W];
    assign green_open_thresh_o =
        cfg.ftb[`LMFB_GREEN_OPEN_LSB +: `LMFB_OPEN_W];
    assign blue_open_thresh_o =
        cfg.ftb[`LMFB_BLUE_OPEN_LSB +: `LMFB_OPEN_W];
    assign fault_readback_en_o = cfg.ftb[`LMFB_RB_EN_BIT];
    assign red_colour_level_o =
        cfg.ftb[`LMFB_RED_LVL_LSB +: `LMFB_LVL_W];
    assign green_colour_level_o =
        cfg.ftb[`LMFB_GREEN_LVL_LSB +: `LMFB_LVL_W];
    assign blue_colour_level_o =
        cfg.ftb[`LMFB_BLUE_LVL_LSB +: `LMFB_LVL_W];
    assign global_level_o =
        cfg.ftb[`LMFB_GLOBAL_LSB +: `LMFB_GLOBAL_W];
    // raw code; the analog side adds one to get the level
    assign short_removal_level_o =
        cfg.ftb[`LMFB_REMOVAL_LSB +: `LMFB_REMOVAL_W];
    // red steps 0.2 to 1.8 V; green and blue step up to 2.8 V
    assign red_short_thresh_o =
        cfg.ftb[`LMFB_RED_SHORT_LSB +: `LMFB_SHORT_W];
    assign green_short_thresh_o =
        cfg.ftb[`LMFB_GREEN_SHORT_LSB +: `LMFB_SHORT_W];
    assign blue_short_thresh_o =
        cfg.ftb[`LMFB_BLUE_SHORT_LSB +: `LMFB_SHORT_W];
    assign slew_decouple_scan_cfg_o = cfg.sds;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_access_start;
        psel_i && penable_i && !pready_o;
    endsequence

    sequence s_one_wait;
        pready_o ##1 !pready_o;
    endsequence

    a_apb_one_wait: assert property (
        s_access_start |=> s_one_wait)
        else $error("apb answer not after exactly one wait state");

    a_red_open_load: assert property (
        cfg.wr_ftb |=> red_open_thresh_o == $past(st_reg.stage_ftb[1:0]))
        else $error("red open threshold not taken from committed word");

    a_green_open_rst: assert property (
        $fell(sys_rst_i) |-> green_open_thresh_o == 2'h0)
        else $error("green open threshold reset value wrong");

    a_blue_open_load: assert property (
        cfg.wr_ftb |=> blue_open_thresh_o == $past(st_reg.stage_ftb[5:4]))
        else $error("blue open threshold not taken from committed word");

    a_readback_gate: assert property (
        pready_o && psel_i && !pwrite_i &&
        paddr_i == `LMFB_OFS_STATUS && !fault_readback_en_o
        |-> prdata_o[5:0] == 6'h00)
        else $error("fault results visible while readback is off");

    a_red_level_rst: assert property (
        $fell(sys_rst_i) |-> red_colour_level_o == `LMFB_COLOUR_RST)
        else $error("red colour level reset value wrong");

    a_green_level_rst: assert property (
        $fell(sys_rst_i) |-> green_colour_level_o == `LMFB_COLOUR_RST)
        else $error("green colour level reset value wrong");

    a_blue_level_load: assert property (
        cfg.wr_ftb |=> blue_colour_level_o == $past(st_reg.stage_ftb[31:24]))
        else $error("blue colour level not taken from committed word");

    a_global_rst: assert property (
        $fell(sys_rst_i) |-> global_level_o == `LMFB_GLOBAL_RST)
        else $error("global level reset value wrong");

    a_removal_load: assert property (
        cfg.wr_ftb |=> short_removal_level_o == $past(pwdata_i[6:3]))
        else $error("short removal code not taken from high word");

    a_red_short_load: assert property (
        cfg.wr_ftb |=> red_short_thresh_o == $past(pwdata_i[9:7]))
        else $error("red short threshold not taken from high word");

    a_green_short_load: assert property (
        cfg.wr_ftb |=> green_short_thresh_o == $past(pwdata_i[12:10]))
        else $error("green short threshold not taken from high word");

    a_blue_short_rst: assert property (
        $fell(sys_rst_i) |-> blue_short_thresh_o == 3'h0)
        else $error("blue short threshold reset value wrong");

    a_reserved_fixed: assert property (
        pready_o && psel_i && !pwrite_i && !pslverr_o &&
        paddr_i == `LMFB_OFS_FTB_LO |-> prdata_o[`LMFB_RSVD_BIT] == 1'b0)
        else $error("reserved bit of fault register reads non-zero");

    a_commit_clears: assert property (
        cfg.wr_ftb |=> !st_reg.pend_ftb ##0 slew_decouple_scan_cfg_o ==
            $past(slew_decouple_scan_cfg_o))
        else $error("high-word commit left pending flag or hit other reg");

    a_red_open_rst: assert property (
        $fell(sys_rst_i) |-> red_open_thresh_o == 2'h0)
        else $error("red open threshold reset value wrong");

    a_green_open_load: assert property (
        cfg.wr_ftb |=> green_open_thresh_o == $past(st_reg.stage_ftb[3:2]))
        else $error("green open threshold not taken from committed word");

    a_blue_open_rst: assert property (
        $fell(sys_rst_i) |-> blue_open_thresh_o == 2'h0)
        else $error("blue open threshold reset value wrong");

    a_readback_load: assert property (
        cfg.wr_ftb |=> fault_readback_en_o == $past(st_reg.stage_ftb[7]))
        else $error("readback enable not taken from committed word");

    a_readback_rst: assert property (
        $fell(sys_rst_i) |-> !fault_readback_en_o)
        else $error("readback enable reset value wrong");

    a_red_level_load: assert property (
        cfg.wr_ftb |=> red_colour_level_o == $past(st_reg.stage_ftb[15:8]))
        else $error("red colour level not taken from committed word");

    a_green_level_load: assert property (
        cfg.wr_ftb |=> green_colour_level_o == $past(st_reg.stage_ftb[23:16]))
        else $error("green colour level not taken from committed word");

    a_blue_level_rst: assert property (
        $fell(sys_rst_i) |-> blue_colour_level_o == `LMFB_COLOUR_RST)
        else $error("blue colour level reset value wrong");

    a_global_load: assert property (
        cfg.wr_ftb |=> global_level_o == $past(pwdata_i[2:0]))
        else $error("global level not taken from high word");

    a_removal_rst: assert property (
        $fell(sys_rst_i) |-> short_removal_level_o == `LMFB_REMOVAL_RST)
        else $error("short removal code reset value wrong");

    a_red_short_rst: assert property (
        $fell(sys_rst_i) |-> red_short_thresh_o == 3'h0)
        else $error("red short threshold reset value wrong");

    a_green_short_rst: assert property (
        $fell(sys_rst_i) |-> green_short_thresh_o == 3'h0)
        else $error("green short threshold reset value wrong");

    a_blue_short_load: assert property (
        cfg.wr_ftb |=> blue_short_thresh_o == $past(pwdata_i[15:13]))
        else $error("blue short threshold not taken from high word");

    a_sds_reserved: assert property (
        cfg.wr_sds |=> (slew_decouple_scan_cfg_o & ~`LMFB_SDS_WMASK) ==
            (`LMFB_SDS_RST & ~`LMFB_SDS_WMASK))
        else $error("reserved bits of second register took a write");

    a_fields_hold: assert property (
        !cfg.wr_ftb |=> $stable(red_colour_level_o) &&
            $stable(short_removal_level_o))
        else $error("fault register fields moved without a commit");
endmodule : lmfb_cfg_top
`default_nettype wire

// ### lmfb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmfb_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [7:0]  paddr_o,
    output logic      [31:0] pwdata_o
);
    logic [31:0] last_rdata;
    logic        last_err;

    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
    end

    // ==========================================================
    // one apb transfer; waits on pready with no cycle count assumed
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] data);
        @(posedge ref_clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= addr;
        pwdata_o  <= data;
        @(posedge ref_clk_i);
        penable_o <= 1'b1;
        // pready is taken at the rising edge, as the slave sees it
        do @(posedge ref_clk_i); while (pready_i !== 1'b1);
        last_rdata = prdata_i;
        last_err   = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // released lines must not keep looking valid
        paddr_o   <= ~paddr_o;
        pwdata_o  <= ~pwdata_o;
    endtask : xfer

    // whole-word update: low half stages, high half commits
    task automatic write48(input logic [7:0] lo_addr,
                           input logic [47:0] value,
                           input logic [15:0] junk);
        xfer(1'b1, lo_addr, value[31:0]);
        xfer(1'b1, lo_addr + 8'h04, {junk, value[47:32]});
    endtask : write48
endmodule : lmfb_host_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmfb_params.svh"
module tb;
    import lmfb_pkg::*;
    localparam lmfb_cfg48_t FTB_RST = 48'h003B_7F7F_7F00;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  open_det = 3'h0;
    logic [2:0]  short_det = 3'h0;
    wire         psel, penable, pwrite, pready, pslverr, rb_en;
    wire [7:0]   paddr, red_lvl, green_lvl, blue_lvl;
    wire [31:0]  pwdata, prdata;
    wire [1:0]   red_open, green_open, blue_open;
    wire [2:0]   global_lvl, red_short, green_short, blue_short;
    wire [3:0]   removal;
    lmfb_cfg48_t sds_o, exp_ftb, exp_sds, v;
    logic [31:0] stage_ftb, stage_sds;
    logic        pend_ftb, pend_sds;
    int          errors = 0;
    int          checks_done = 0;
    logic [7:0]  bad_addr [4] = '{8'h14, 8'h01, 8'h06, 8'hFC};
    wire lmfb_cfg48_t fields = {blue_short, green_short, red_short,
        removal, global_lvl, blue_lvl, green_lvl, red_lvl, rb_en, 1'b0,
        blue_open, green_open, red_open};

    always #50 ref_clk = ~ref_clk;

    lmfb_host_model u_lmfb_host_model (.ref_clk_i(ref_clk),
        .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));

    lmfb_cfg_top u_lmfb_cfg_top (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .open_load_detect_i(open_det), .short_detect_i(short_det),
        .red_open_thresh_o(red_open), .green_open_thresh_o(green_open),
        .blue_open_thresh_o(blue_open), .fault_readback_en_o(rb_en),
        .red_colour_level_o(red_lvl), .green_colour_level_o(green_lvl),
        .blue_colour_level_o(blue_lvl), .global_level_o(global_lvl),
        .short_removal_level_o(removal), .red_short_thresh_o(red_short),
        .green_short_thresh_o(green_short),
        .blue_short_thresh_o(blue_short),
        .slew_decouple_scan_cfg_o(sds_o));

    // ==========================================================
    // expectation helpers
    function automatic lmfb_cfg48_t sds_fix(input lmfb_cfg48_t x);
        return (x & `LMFB_SDS_WMASK) | (`LMFB_SDS_RST & ~`LMFB_SDS_WMASK);
    endfunction : sds_fix
    function automatic logic [31:0] status_exp();
        return {22'h0, pend_sds, pend_ftb, 2'b00,
                short_det & {3{exp_ftb[7]}}, open_det & {3{exp_ftb[7]}}};
    endfunction : status_exp
    task automatic exp_reset();
        exp_ftb = FTB_RST;
        exp_sds = `LMFB_SDS_RST;
        stage_ftb = FTB_RST[31:0];
        stage_sds = exp_sds[31:0];
        pend_ftb = 1'b0;
        pend_sds = 1'b0;
    endtask : exp_reset

    // ==========================================================
    // compares
    task automatic cmp48(input lmfb_cfg48_t got, input lmfb_cfg48_t exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp48
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp32
    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp1

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic e_err);
        u_lmfb_host_model.xfer(1'b0, a, 32'h0);
        cmp32(u_lmfb_host_model.last_rdata, e);
        cmp1(u_lmfb_host_model.last_err, e_err);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_lmfb_host_model.xfer(1'b1, a, d);
        cmp1(u_lmfb_host_model.last_err, 1'b0);
        case (a)
            `LMFB_OFS_FTB_LO: begin stage_ftb = d; pend_ftb = 1'b1; end
            `LMFB_OFS_SDS_LO: begin stage_sds = d; pend_sds = 1'b1; end
            `LMFB_OFS_FTB_HI: begin
                exp_ftb = {d[15:0], stage_ftb} & ~48'h40;
                pend_ftb = 1'b0;
            end
            default: begin
                exp_sds = sds_fix({d[15:0], stage_sds});
                pend_sds = 1'b0;
            end
        endcase
    endtask : wr
    task automatic check_state();
        @(posedge ref_clk);
        open_det  <= 3'($urandom);
        short_det <= 3'($urandom);
        rd(`LMFB_OFS_FTB_LO, exp_ftb[31:0], 1'b0);
        rd(`LMFB_OFS_FTB_HI, {16'h0, exp_ftb[47:32]}, 1'b0);
        rd(`LMFB_OFS_SDS_LO, exp_sds[31:0], 1'b0);
        rd(`LMFB_OFS_SDS_HI, {16'h0, exp_sds[47:32]}, 1'b0);
        rd(`LMFB_OFS_STATUS, status_exp(), 1'b0);
        cmp48(fields, exp_ftb);
        cmp48(sds_o, exp_sds);
    endtask : check_state

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        void'($urandom(12571));
        exp_reset();
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check_state();
        $display("test reset_values done");
        // corner words first, then random; some high writes reuse staging
        for (int i = 0; i < 24; i++) begin
            v = (i < 2) ? {48{i == 0}} : 48'({$urandom, $urandom});
            if (i % 3 != 2) begin
                wr((i % 2) ? `LMFB_OFS_SDS_LO : `LMFB_OFS_FTB_LO, v[31:0]);
                check_state();
            end
            wr((i % 2) ? `LMFB_OFS_SDS_HI : `LMFB_OFS_FTB_HI,
               {16'($urandom), v[47:32]});
            check_state();
        end
        $display("test random_commits done");
        foreach (bad_addr[k]) begin
            rd(bad_addr[k], 32'h0, 1'b1);
            u_lmfb_host_model.xfer(1'b1, bad_addr[k], $urandom);
            cmp1(u_lmfb_host_model.last_err, 1'b1);
        end
        u_lmfb_host_model.xfer(1'b1, `LMFB_OFS_STATUS, 32'hFFFF_FFFF);
        cmp1(u_lmfb_host_model.last_err, 1'b1);
        check_state();
        $display("test refused_access done");
        u_lmfb_host_model.write48(`LMFB_OFS_FTB_LO, 48'hFFFF_FFFF_FFFF,
                                  16'hA5C3);
        stage_ftb = 32'hFFFF_FFFF;
        exp_ftb = 48'hFFFF_FFFF_FFFF & ~48'h40;
        check_state();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        exp_reset();
        check_state();
        $display("test mid_run_reset done");
        summarize();
    end
endmodule : tb
`default_nettype wire
